// ===== rtl/kmi_pkg.sv
// kmi_pkg: register map, reset values and widths for the keypad interrupt block.
// assumes a 32-bit ahb-lite register bus with word-aligned registers.
package kmi_pkg;
	localparam int          KEY_COUNT          = 8;
	localparam int          SYNC_STAGES        = 3;
	localparam logic [11:0] LEVEL_SELECT_ADDR  = 12'h000;
	localparam logic [11:0] MASK_ENABLE_ADDR   = 12'h004;
	localparam logic [11:0] DETECT_FLAGS_ADDR  = 12'h008;
	localparam logic [11:0] SECOND_INT_ADDR    = 12'h00c;
	localparam logic [11:0] PIN_STATE_ADDR     = 12'h010;
	localparam logic [11:0] WAKE_STATUS_ADDR   = 12'h014;
	localparam int          GLOBAL_ENABLE_BIT  = 0;
	localparam int          WAKE_PENDING_BIT   = 0;
	localparam logic [7:0]  LEVEL_SELECT_RESET = 8'h00;
	localparam logic [7:0]  MASK_ENABLE_RESET  = 8'h00;
	localparam logic [7:0]  DETECT_FLAGS_RESET = 8'h00;
	localparam logic        GLOBAL_EN_RESET    = 1'b0;
	localparam logic [1:0]  HTRANS_NONSEQ      = 2'h2;
	localparam logic [1:0]  HTRANS_SEQ         = 2'h3;
endpackage : kmi_pkg

// ===== rtl/kmi_pin_sync.sv
// kmi_pin_sync: three-flop synchroniser per port-one pin with agreement filter.
// assumes pins are asynchronous to sys_clk_in; output changes once stages 2 and 3 agree.
`timescale 1ns/10ps
module kmi_pin_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             sys_clk_in,
	input  wire logic             rst_in,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level_out
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] level;
	} kmi_sync_state_t;

	kmi_sync_state_t state;
	kmi_sync_state_t next_state;

	initial begin
		if (WIDTH < 1) begin
			$error("kmi_pin_sync: WIDTH must be at least 1");
		end
	end

	always_comb begin
		next_state    = state;
		next_state.s1 = pin_in;
		next_state.s2 = state.s1;
		next_state.s3 = state.s2;
		for (int i = 0; i < WIDTH; i++) begin
			// a glitch that shows in only one stage never reaches the detector
			if (state.s2[i] == state.s3[i]) begin
				next_state.level[i] = state.s3[i];
			end
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			// pins idle high on their pull-ups, so start there and fake no level after reset
			state <= '1;
		end else begin
			state <= next_state;
		end
	end

	assign level_out = state.level;
endmodule : kmi_pin_sync

// ===== rtl/kmi_keypad_irq.sv
// kmi_keypad_irq: keypad level-detect interrupt logic on port one with ahb-lite registers.
// assumes one clock sys_clk_in, the core's power controller acting on wake_out.
// Functional notes
// - There are eight independent keypad sense inputs, each a level-detect channel.
// - Each input's active level (high or low) is picked by its key_level_select bit.
// - The keypad inputs are an alternate use of the eight port one pins.
// - A detected level on an enabled input raises a wake request out of idle and power-down.
// - All eight inputs are separate sources sharing one interrupt request line.
// - The key_global_enable bit in second_int_enable_reg gates the shared request as a whole.
// - An input seeing its selected level sets its own key_detect_flags bit.
// - Each flag is masked by its key_mask_enable bit and a masked flag adds nothing.
// - Any subset of inputs may be used for the keypad; unused pins stay free for other use.
`timescale 1ns/10ps
module kmi_keypad_irq #(
	parameter int KEYS = kmi_pkg::KEY_COUNT
) (
	input  wire logic            sys_clk_in,
	input  wire logic            rst_in,
	input  wire logic [KEYS-1:0] port_one_pins_in,
	output logic      [KEYS-1:0] port_one_level_out,
	output logic                 key_irq_out,
	output logic                 wake_out,
	input  wire logic            hsel_in,
	input  wire logic [31:0]     haddr_in,
	input  wire logic [1:0]      htrans_in,
	input  wire logic            hwrite_in,
	input  wire logic [2:0]      hsize_in,
	input  wire logic [31:0]     hwdata_in,
	input  wire logic            hready_in,
	output logic      [31:0]     hrdata_out,
	output logic                 hreadyout_out,
	output logic                 hresp_out
);
	initial begin
		if (KEYS != kmi_pkg::KEY_COUNT) begin
			$error("kmi_keypad_irq: KEYS must be 8, registers are one byte wide");
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [KEYS-1:0] level_select;
		logic [KEYS-1:0] mask_enable;
		logic [KEYS-1:0] detect_flags;
		logic            global_enable;
		logic            irq;
		logic            wake;
		logic            dp_write;
		logic            dp_read;
		logic [11:0]     dp_addr;
		logic [31:0]     rdata;
	} kmi_state_t;

	kmi_state_t      state;
	kmi_state_t      next_state;
	logic [KEYS-1:0] key_level;
	logic [KEYS-1:0] key_hit;
	logic            addr_phase;

	////////////////////////////////////////////////////////////////////////////////
	// pin sampling

	// port one pins feed general-purpose reads as well as the keypad logic
	kmi_pin_sync #(
		.WIDTH      (KEYS)
	) u_pin_sync (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.pin_in     (port_one_pins_in),
		.level_out  (key_level)
	);

	genvar g;
	generate
		for (g = 0; g < KEYS; g++) begin : g_key
			// select bit high means a high level is active
			assign key_hit[g] = ~(key_level[g] ^ state.level_select[g]);
		end
	endgenerate

	assign addr_phase = hsel_in && hready_in &&
		(htrans_in == kmi_pkg::HTRANS_NONSEQ || htrans_in == kmi_pkg::HTRANS_SEQ);

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_state          = state;
		next_state.dp_write = 1'b0;
		next_state.dp_read  = 1'b0;

		// data phase of a write: a flag written as one is cleared
		if (state.dp_write) begin
			case (state.dp_addr)
				kmi_pkg::LEVEL_SELECT_ADDR: begin
					next_state.level_select = hwdata_in[KEYS-1:0];
				end
				kmi_pkg::MASK_ENABLE_ADDR: begin
					next_state.mask_enable = hwdata_in[KEYS-1:0];
				end
				kmi_pkg::DETECT_FLAGS_ADDR: begin
					next_state.detect_flags = state.detect_flags & ~hwdata_in[KEYS-1:0];
				end
				kmi_pkg::SECOND_INT_ADDR: begin
					next_state.global_enable = hwdata_in[kmi_pkg::GLOBAL_ENABLE_BIT];
				end
				default: begin
				end
			endcase
		end

		// set after clear so a level seen in the clearing cycle is kept
		next_state.detect_flags = next_state.detect_flags | key_hit;

		// masked flags never reach the line, even though they still record
		next_state.irq  = state.global_enable &&
			|(state.detect_flags & state.mask_enable);
		// wake looks at the live level so a key held during power-down is seen at once
		next_state.wake = state.global_enable &&
			|((state.detect_flags | key_hit) & state.mask_enable);

		if (addr_phase) begin
			next_state.dp_addr  = haddr_in[11:0];
			next_state.dp_write = hwrite_in;
			next_state.dp_read  = ~hwrite_in;
			next_state.rdata    = 32'h0000_0000;
			case (haddr_in[11:0])
				kmi_pkg::LEVEL_SELECT_ADDR: begin
					next_state.rdata[KEYS-1:0] = state.level_select;
				end
				kmi_pkg::MASK_ENABLE_ADDR: begin
					next_state.rdata[KEYS-1:0] = state.mask_enable;
				end
				kmi_pkg::DETECT_FLAGS_ADDR: begin
					next_state.rdata[KEYS-1:0] = state.detect_flags;
				end
				kmi_pkg::SECOND_INT_ADDR: begin
					next_state.rdata[kmi_pkg::GLOBAL_ENABLE_BIT] = state.global_enable;
				end
				kmi_pkg::PIN_STATE_ADDR: begin
					next_state.rdata[KEYS-1:0] = key_level;
				end
				kmi_pkg::WAKE_STATUS_ADDR: begin
					next_state.rdata[kmi_pkg::WAKE_PENDING_BIT] = state.wake;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state               <= '0;
			state.level_select  <= kmi_pkg::LEVEL_SELECT_RESET;
			state.mask_enable   <= kmi_pkg::MASK_ENABLE_RESET;
			state.detect_flags  <= kmi_pkg::DETECT_FLAGS_RESET;
			state.global_enable <= kmi_pkg::GLOBAL_EN_RESET;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign port_one_level_out = key_level;
	assign key_irq_out        = state.irq;
	assign wake_out           = state.wake;
	assign hrdata_out         = state.rdata;
	assign hreadyout_out      = 1'b1;
	assign hresp_out          = 1'b0;
endmodule : kmi_keypad_irq

// ===== tb/kmi_keys.sv
// kmi_keys: keypad switches from port one lines to ground, lines held by pull-ups.
// assumes one bench bit per key; an open key always reads high, never floats.
`timescale 1ns/10ps
module kmi_keys #(
	parameter int KEYS = 8
) (
	input  wire logic [KEYS-1:0] press_in,
	output logic      [KEYS-1:0] pins_out
);
	assign pins_out = ~press_in;
endmodule : kmi_keys

// ===== tb/kmi_checker.sv
// kmi_checker: port assertions for the keypad interrupt block.
// assumes word writes and the slave's hreadyout fed back as hready_in.
`timescale 1ns/10ps
module kmi_checker #(
	parameter int KEYS = 8
) (
	input wire logic            sys_clk_in,
	input wire logic            rst_in,
	input wire logic [KEYS-1:0] port_one_pins_in,
	input wire logic [KEYS-1:0] port_one_level_out,
	input wire logic            key_irq_out,
	input wire logic            wake_out,
	input wire logic            hsel_in,
	input wire logic [31:0]     haddr_in,
	input wire logic [1:0]      htrans_in,
	input wire logic            hwrite_in,
	input wire logic [31:0]     hwdata_in,
	input wire logic [31:0]     hrdata_out
);
	logic       en_q, mk_q, en_sh;
	logic [7:0] msk_sh;
	wire        req = hsel_in && htrans_in[1];
	// shadow of the gate bits, loaded in the data phase as the slave does
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			{en_q, mk_q, en_sh, msk_sh} <= 11'h000;
		end else begin
			en_q   <= req && hwrite_in && haddr_in[11:0] == kmi_pkg::SECOND_INT_ADDR;
			mk_q   <= req && hwrite_in && haddr_in[11:0] == kmi_pkg::MASK_ENABLE_ADDR;
			en_sh  <= en_q ? hwdata_in[0] : en_sh;
			msk_sh <= mk_q ? hwdata_in[7:0] : msk_sh;
		end
	end
	////////////////
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	a_sync_follow: assert property ($stable(port_one_pins_in)[*6] |->
		port_one_level_out == port_one_pins_in) else $error("pin level lags");
	a_pin_read: assert property (req && !hwrite_in && haddr_in[11:0] == kmi_pkg::PIN_STATE_ADDR
		##1 $stable(port_one_level_out) |-> hrdata_out[7:0] == port_one_level_out)
		else $error("pin state read");
	a_upper_zero: assert property (hrdata_out[31:8] == 24'h000000) else $error("upper");
	a_wake_leads: assert property ($rose(key_irq_out) |-> wake_out) else $error("wake");
	a_wake_gated: assert property (wake_out |-> $past(en_sh) && $past(msk_sh) != 8'h00)
		else $error("wake ungated");
	a_gate_off: assert property ((!en_sh)[*3] |-> !key_irq_out && !wake_out)
		else $error("global gate");
	a_mask_off: assert property ((msk_sh == 8'h00)[*3] |-> !key_irq_out)
		else $error("mask");
	a_irq_cause: assert property ($rose(key_irq_out) |-> $past(en_sh) && $past(msk_sh) != 8'h00)
		else $error("irq cause");
	c_irq_rise: cover property ($rose(key_irq_out));
	c_irq_fall: cover property ($fell(key_irq_out));
	c_wake: cover property ($rose(wake_out));
endmodule : kmi_checker

bind kmi_keypad_irq kmi_checker #(.KEYS(KEYS)) u_kmi_chk (.sys_clk_in, .rst_in,
	.port_one_pins_in, .port_one_level_out, .key_irq_out, .wake_out, .hsel_in,
	.haddr_in, .htrans_in, .hwrite_in, .hwdata_in, .hrdata_out);

// ===== tb/tb_top.sv
// tb_top: register and key tests of the keypad interrupt block.
// assumes a zero-wait slave; the bench is the only bus master.
`timescale 1ns/10ps
module tb_top;
	logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwr = 1'b0;
	logic [1:0]  htr = 2'h0;
	logic [31:0] ha = 32'h0, hwd = 32'h0;
	logic [7:0]  press = 8'h00;
	wire  [7:0]  pins;
	wire  [31:0] hrd;
	wire         irq, wake, rdy;
	int          mismatches = 0, n_compared = 0;
	always #25 clk = ~clk;
	kmi_keys u_keys (.press_in(press), .pins_out(pins));
	kmi_keypad_irq uut (.sys_clk_in(clk), .rst_in(rst), .port_one_pins_in(pins),
		.port_one_level_out(), .key_irq_out(irq), .wake_out(wake), .hsel_in(hsel),
		.haddr_in(ha), .htrans_in(htr), .hwrite_in(hwr), .hsize_in(3'h2), .hwdata_in(hwd),
		.hready_in(rdy), .hrdata_out(hrd), .hreadyout_out(rdy), .hresp_out());
	////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: %h not %h", $time, got, exp);
		end
	endtask : chk
	// one transfer; on a read d is the value expected back
	task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
		{hsel, htr, hwr, ha} <= {1'b1, kmi_pkg::HTRANS_NONSEQ, w, 20'h0, a};
		do @(posedge clk); while (rdy !== 1'b1);
		{hsel, htr, hwd} <= {1'b0, 2'h0, w ? d : 32'h0};
		do @(posedge clk); while (rdy !== 1'b1);
		if (!w)
			chk(hrd, d);
	endtask : acc
	// five edges of sync to the flag, one more to the request, one more to see it settled
	task settle;
		repeat (7) @(posedge clk);
	endtask : settle
	task tally_and_finish;
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (3000) @(posedge clk);
		mismatches++;
		tally_and_finish();
	end
	////////////////
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		settle();
		acc(0, 12'h000, 32'h0);
		acc(0, 12'h004, 32'h0);
		acc(0, 12'h00c, 32'h0);
		acc(0, 12'h010, 32'hff);
		acc(0, 12'h008, 32'h0);
		acc(1, 12'h008, 32'hff);
		acc(0, 12'h008, 32'h0);
		acc(1, 12'h018, 32'hff);
		acc(0, 12'h018, 32'h0);
		$display("test reset done");
		press <= 8'h08;
		settle();
		acc(0, 12'h008, 32'h08);
		acc(0, 12'h010, 32'hf7);
		acc(1, 12'h004, 32'h08);
		settle();
		chk(32'(irq), 32'h0);
		acc(1, 12'h00c, 32'h1);
		settle();
		chk(32'({irq, wake}), 32'h3);
		press <= 8'h00;
		settle();
		acc(0, 12'h008, 32'h08);
		acc(1, 12'h008, 32'h08);
		settle();
		chk(32'({irq, wake}), 32'h0);
		$display("test low level done");
		acc(1, 12'h000, 32'hff);
		for (int i = 0; i < 8; i++) begin
			press <= 8'h01 << i;
			settle();
			acc(1, 12'h008, 32'hff);
			acc(0, 12'h008, {24'h0, ~(8'h01 << i)});
		end
		chk(32'(irq), 32'h1);
		acc(1, 12'h004, 32'h80);
		settle();
		chk(32'({irq, wake}), 32'h0);
		$display("test high level done");
		tally_and_finish();
	end
endmodule : tb_top
